// File: verilog/slfs_pkg.sv
// Shared constants and types of the supply lockout and fault supervisor
package slfs_pkg;

   // Core clock period and derived timing counts
   localparam int unsigned CLK_PERIOD_NS  = 40;
   localparam int unsigned SYNC_LOW_NS    = 500;
   localparam int unsigned SYNC_PERIOD_NS = 2000;
   localparam int unsigned TB_PERIOD_NS   = 10000;
   localparam int unsigned TB_LOW_NS      = 1000;
   localparam int unsigned SYNC_LOW_CYC   =
      (SYNC_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SYNC_PER_CYC   = SYNC_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned TB_LOW_CYC     =
      (TB_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TB_PER_CYC     = TB_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned CNT_W          = 8;

   // Die temperature thresholds in degrees C
   localparam logic [7:0] TEMP_BLOCK_C   = 8'h82;
   localparam logic [7:0] TEMP_UNBLOCK_C = 8'h78;

   // Bus addresses and command codes
   localparam logic [6:0] ADDR_FIXED_A   = 7'h5a;
   localparam logic [6:0] ADDR_GLOBAL    = 7'h5b;
   localparam logic [7:0] CMD_UNLOCK     = 8'hbd;
   localparam logic [7:0] UNLOCK_KEY1    = 8'h2b;
   localparam logic [7:0] UNLOCK_KEY2    = 8'hc4;
   localparam logic [7:0] CMD_SOFT_RESET = 8'hfd;

   // Fault source positions within a channel's source vector
   localparam int unsigned NUM_CH   = 2;
   localparam int unsigned NUM_FLT  = 6;
   localparam int unsigned FLT_OV   = 0;
   localparam int unsigned FLT_UV   = 1;
   localparam int unsigned FLT_OC   = 2;
   localparam int unsigned FLT_OT   = 3;
   localparam int unsigned FLT_TIM  = 4;
   localparam int unsigned FLT_PKOC = 5;

   // Common status byte fields, reset values
   localparam int unsigned ST_VIN_OK      = 0;
   localparam int unsigned ST_NVM_BLOCK   = 1;
   localparam int unsigned ST_NEED_RST    = 2;
   localparam int unsigned ST_NVM_INIT_N  = 3;
   localparam logic [15:0] PEAK_RST       = 16'h0000;
   localparam logic [15:0] RETRY_RST      = 16'h0000;

   // Per-source fault response
   typedef enum logic [1:0] {
      RESP_IGNORE = 2'b00,
      RESP_LATCH  = 2'b01,
      RESP_RETRY  = 2'b10
   } slfs_resp_t;

   // Channel power state
   typedef enum logic [1:0] {
      CH_OFF     = 2'b00,
      CH_ON      = 2'b01,
      CH_LATCHED = 2'b10,
      CH_RETRY   = 2'b11
   } slfs_ch_t;

endpackage : slfs_pkg

// File: verilog/slfs_sync.sv
// Two flip-flop level synchroniser with asynchronous clear
`timescale 1ns/1ps
`default_nettype none
module slfs_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] held;
   } slfs_sync_st_t;

   slfs_sync_st_t st_ff;
   slfs_sync_st_t nxt_st;

   // First stage feeds only the second
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.meta = d;
      nxt_st.held = st_ff.meta;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign q = st_ff.held;
endmodule : slfs_sync
`default_nettype wire

// File: verilog/slfs_supervisor.sv
// Supply lockout, unlock sequence and fault supervisor top
// Functional notes
// - Hold all sequencing until input rises above turn-on threshold.
// - Below turn-off threshold pull timebase low; restart needs turn-on.
// - Fault line low at first input power asserts alert despite masking.
// - Partial transaction on the link asserts alert.
// - Memory powered without input ever: status bit 3 reads low.
// - While uninitialized, acknowledge only fixed addresses 5A and 5B.
// - After unlock, respond at the configured address.
// - Digital side and command port work without input voltage.
// - Each channel's fault pin maskable per fault source.
// - Fault line pulled low externally is a system fault input.
// - Per source response: ignore, latch off, or retry at interval.
// - Overvoltage forces top gate low, bottom gate high, always.
// - With logging on, store a log record on a fault turn-off; others before it is written share it.
// - Peak header readable at any time.
// - Block memory above 130 C until below 120 C.
// - Listed pins are open-drain, only ever pulled low.
// - Sync line pulled low about 500 ns each switching period.
// - Timebase period 10 us with 1 us low time.
`timescale 1ns/1ps
`default_nettype none
module slfs_supervisor
   import slfs_pkg::*;
(
   input  wire logic                    core_clk,
   input  wire logic                    resetn,
   input  wire logic                    input_turn_on_threshold,
   input  wire logic                    input_turn_off_threshold,
   input  wire logic [slfs_pkg::NUM_CH-1:0] fault_line_n_i,
   output logic      [slfs_pkg::NUM_CH-1:0] fault_line_n_oe,
   input  wire logic [slfs_pkg::NUM_CH-1:0] channel_on_request_n_i,
   output logic      [slfs_pkg::NUM_CH-1:0] channel_on_request_n_oe,
   output logic      [slfs_pkg::NUM_CH-1:0] power_good_n_oe,
   output logic                         sync_oe,
   output logic                         share_clk_oe,
   output logic                         alert_n_oe,
   output logic                         scl_oe,
   output logic                         sda_oe,
   input  wire logic [slfs_pkg::NUM_CH-1:0][slfs_pkg::NUM_FLT-1:0] flt_src,
   input  wire logic [slfs_pkg::NUM_CH-1:0][slfs_pkg::NUM_FLT-1:0] flt_pin_mask,
   input  wire logic [slfs_pkg::NUM_CH-1:0][slfs_pkg::NUM_FLT-1:0][1:0] flt_resp,
   input  wire logic [1:0]              ext_flt_resp,
   input  wire logic                    alert_mask_ext,
   input  wire logic                    alert_clear,
   input  wire logic [15:0]             fault_retry_interval,
   input  wire logic                    sync_out_en,
   input  wire logic [6:0]              cfg_addr,
   input  wire logic [slfs_pkg::NUM_CH-1:0] pwm_top,
   input  wire logic [slfs_pkg::NUM_CH-1:0] pwm_bot,
   output logic      [slfs_pkg::NUM_CH-1:0] top_gate_drive,
   output logic      [slfs_pkg::NUM_CH-1:0] bottom_gate_drive,
   output logic      [slfs_pkg::NUM_CH-1:0] pwm_enable,
   output logic      [7:0]              common_status_byte,
   input  wire logic                    fault_log_en,
   output logic                         nvm_log_store,
   input  wire logic                    nvm_req,
   output logic                         nvm_grant,
   input  wire logic [7:0]              die_temp,
   input  wire logic [15:0]             peak_meas,
   output logic      [15:0]             peak_hdr,
   input  wire logic                    link_clk,
   input  wire logic                    lk_addr_valid,
   input  wire logic [6:0]              lk_addr,
   input  wire logic                    lk_wr_strobe,
   input  wire logic [7:0]              lk_cmd,
   input  wire logic [7:0]              lk_data,
   input  wire logic                    lk_partial
);
   import slfs_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] sync_cnt;
      logic [CNT_W-1:0] tb_cnt;
      logic             vin_ok;
      logic             vin_seen;
      logic             unlocked;
      logic             key1_seen;
      logic             need_rst;
      logic             nvm_block;
      logic             cml_flt;
      logic             pwrup_flt;
      logic             ext_flt;
      logic             wr_tog_q;
      logic             pt_tog_q;
      logic [15:0]      peak;
      logic             log_pend;
      logic             log_store;
      slfs_ch_t [NUM_CH-1:0] ch_st;
      logic [NUM_CH-1:0][15:0] retry_cnt;
      logic [NUM_CH-1:0] pull_now;
      logic [NUM_CH-1:0] pull_d1;
      logic [NUM_CH-1:0] pull_d2;
      logic [NUM_CH-1:0] tg;
      logic [NUM_CH-1:0] bg;
   } slfs_core_st_t;

   typedef struct packed {
      logic       sel;
      logic       ack;
      logic       glob;
      logic       wr_tog;
      logic       pt_tog;
      logic [7:0] cmd;
      logic [7:0] data;
   } slfs_link_st_t;

   slfs_core_st_t st_ff;
   slfs_core_st_t nxt_st;
   slfs_link_st_t lk_ff;
   slfs_link_st_t nxt_lk;
   logic          rst_n;
   logic          lk_rst_n;
   logic [7:0]    pin_sync;
   logic [7:0]    lk_sync;
   logic          input_turn_on_threshold_s;
   logic          input_turn_off_threshold_s;
   logic [NUM_CH-1:0] fline_n_s;
   logic [NUM_CH-1:0] run_n_s;
   logic          wr_tog_s;
   logic          pt_tog_s;
   logic          uninit;
   logic          lk_uninit;
   logic [6:0]    lk_cfg_addr;
   logic          seq_ok;

   // Reset release through two flops in each domain
   slfs_sync #(.W(1)) u_rst_core (
      .clk   (core_clk),
      .rst_n (resetn),
      .d     (1'b1),
      .q     (rst_n)
   );

   slfs_sync #(.W(1)) u_rst_link (
      .clk   (link_clk),
      .rst_n (resetn),
      .d     (1'b1),
      .q     (lk_rst_n)
   );

   // Pins and link toggles enter the core domain
   slfs_sync #(.W(8)) u_pin_sync (
      .clk   (core_clk),
      .rst_n (rst_n),
      .d     ({input_turn_on_threshold, input_turn_off_threshold,
               fault_line_n_i, channel_on_request_n_i,
               lk_ff.wr_tog, lk_ff.pt_tog}),
      .q     (pin_sync)
   );

   assign {input_turn_on_threshold_s, input_turn_off_threshold_s, fline_n_s, run_n_s, wr_tog_s, pt_tog_s} =
      pin_sync;

   // Addressing mode enters the link domain; address is static config
   slfs_sync #(.W(8)) u_link_sync (
      .clk   (link_clk),
      .rst_n (lk_rst_n),
      .d     ({uninit, cfg_addr}),
      .q     (lk_sync)
   );

   assign {lk_uninit, lk_cfg_addr} = lk_sync;

   assign uninit = !st_ff.vin_seen && !st_ff.unlocked;
   assign seq_ok = st_ff.vin_ok && !st_ff.need_rst && !uninit;

   // Link side: address decode, then hold a written word and flip a toggle
   always_comb begin
      nxt_lk     = lk_ff;
      nxt_lk.ack = 1'b0;
      if (lk_addr_valid) begin
         if (lk_uninit) begin
            nxt_lk.sel = (lk_addr == ADDR_FIXED_A) ||
                         (lk_addr == ADDR_GLOBAL);
         end else begin
            nxt_lk.sel = (lk_addr == lk_cfg_addr) ||
                         (lk_addr == ADDR_GLOBAL);
         end
         nxt_lk.glob = (lk_addr == ADDR_GLOBAL);
         nxt_lk.ack  = nxt_lk.sel;
      end
      // Word stays put until the next write, so the core reads it safely
      if (lk_wr_strobe && lk_ff.sel) begin
         nxt_lk.cmd    = lk_cmd;
         nxt_lk.data   = lk_data;
         nxt_lk.wr_tog = !lk_ff.wr_tog;
      end
      if (lk_partial) begin
         nxt_lk.pt_tog = !lk_ff.pt_tog;
      end
   end

   always_ff @(posedge link_clk or negedge lk_rst_n) begin
      if (!lk_rst_n) begin
         lk_ff <= '0;
      end else begin
         lk_ff <= nxt_lk;
      end
   end

   // Core side: lockout, unlock, fault handling and timebases
   always_comb begin
      logic             wr_evt;
      logic             tb_tick;
      logic             ext_now;
      logic             any_off;
      logic             lat_hit;
      logic             rty_hit;
      slfs_resp_t       rsp;
      wr_evt  = 1'b0;
      tb_tick = 1'b0;
      ext_now = 1'b0;
      any_off = 1'b0;
      lat_hit = 1'b0;
      rty_hit = 1'b0;
      rsp     = RESP_IGNORE;
      nxt_st  = st_ff;

      // Switching-period sync and 10 us timebase counters
      if (st_ff.sync_cnt == CNT_W'(SYNC_PER_CYC - 1)) begin
         nxt_st.sync_cnt = '0;
      end else begin
         nxt_st.sync_cnt = st_ff.sync_cnt + 1'b1;
      end
      if (st_ff.tb_cnt == CNT_W'(TB_PER_CYC - 1)) begin
         nxt_st.tb_cnt = '0;
         tb_tick       = 1'b1;
      end else begin
         nxt_st.tb_cnt = st_ff.tb_cnt + 1'b1;
      end

      // Input lockout with hysteresis
      if (!st_ff.vin_ok && input_turn_on_threshold_s) begin
         nxt_st.vin_ok = 1'b1;
         if (!st_ff.vin_seen) begin
            nxt_st.vin_seen = 1'b1;
            // Memory was set up without input: demand a soft reset
            nxt_st.need_rst = st_ff.unlocked;
            if (!(&fline_n_s)) begin
               nxt_st.pwrup_flt = 1'b1;
            end
         end
      end else if (st_ff.vin_ok && input_turn_off_threshold_s) begin
         nxt_st.vin_ok = 1'b0;
      end

      // Commands work on the digital supply alone
      wr_evt = wr_tog_s != st_ff.wr_tog_q;
      nxt_st.wr_tog_q = wr_tog_s;
      nxt_st.pt_tog_q = pt_tog_s;
      if (wr_evt) begin
         if (lk_ff.cmd == CMD_UNLOCK && lk_ff.glob) begin
            if (lk_ff.data == UNLOCK_KEY1) begin
               nxt_st.key1_seen = 1'b1;
            end else if (lk_ff.data == UNLOCK_KEY2 && st_ff.key1_seen) begin
               nxt_st.unlocked  = 1'b1;
               nxt_st.key1_seen = 1'b0;
            end else begin
               nxt_st.key1_seen = 1'b0;
            end
         end else begin
            nxt_st.key1_seen = 1'b0;
         end
         if (lk_ff.cmd == CMD_SOFT_RESET) begin
            nxt_st.need_rst = nxt_st.need_rst && !st_ff.vin_seen;
         end
      end

      // Alert flags: a new event beats a clear in the same cycle
      ext_now = |(~fline_n_s & ~(st_ff.pull_now | st_ff.pull_d1 |
                                 st_ff.pull_d2));
      nxt_st.cml_flt   = (st_ff.cml_flt && !alert_clear) ||
                         (pt_tog_s != st_ff.pt_tog_q);
      nxt_st.ext_flt   = (st_ff.ext_flt && !alert_clear) || ext_now;
      nxt_st.pwrup_flt = nxt_st.pwrup_flt && !(alert_clear &&
                         !(nxt_st.pwrup_flt && !st_ff.pwrup_flt));

      // Channel fault pins, gate drives and power state
      for (int c = 0; c < NUM_CH; c++) begin
         nxt_st.pull_now[c] = |(flt_src[c] & flt_pin_mask[c]);
         lat_hit = 1'b0;
         rty_hit = 1'b0;
         for (int s = 0; s < NUM_FLT; s++) begin
            rsp = slfs_resp_t'(flt_resp[c][s]);
            if (flt_src[c][s] && rsp == RESP_LATCH) begin
               lat_hit = 1'b1;
            end
            if (flt_src[c][s] && rsp == RESP_RETRY) begin
               rty_hit = 1'b1;
            end
         end
         rsp = slfs_resp_t'(ext_flt_resp);
         lat_hit = lat_hit || (ext_now && rsp == RESP_LATCH);
         rty_hit = rty_hit || (ext_now && rsp == RESP_RETRY);

         unique case (st_ff.ch_st[c])
            CH_OFF: begin
               if (seq_ok && !run_n_s[c] && !lat_hit && !rty_hit) begin
                  nxt_st.ch_st[c] = CH_ON;
               end
            end
            CH_ON: begin
               if (lat_hit) begin
                  nxt_st.ch_st[c] = CH_LATCHED;
                  any_off = 1'b1;
               end else if (rty_hit) begin
                  nxt_st.ch_st[c]     = CH_RETRY;
                  nxt_st.retry_cnt[c] = fault_retry_interval;
                  any_off = 1'b1;
               end else if (!seq_ok || run_n_s[c]) begin
                  nxt_st.ch_st[c] = CH_OFF;
               end
            end
            CH_LATCHED: begin
               // Stays off until the run line goes high or a soft reset
               if (run_n_s[c] ||
                   (wr_evt && lk_ff.cmd == CMD_SOFT_RESET)) begin
                  nxt_st.ch_st[c] = CH_OFF;
               end
            end
            CH_RETRY: begin
               if (st_ff.retry_cnt[c] == RETRY_RST) begin
                  nxt_st.ch_st[c] = CH_OFF;
               end else if (tb_tick) begin
                  nxt_st.retry_cnt[c] = st_ff.retry_cnt[c] - 1'b1;
               end
            end
         endcase

         if (flt_src[c][FLT_OV]) begin
            nxt_st.tg[c] = 1'b0;
            nxt_st.bg[c] = 1'b1;
         end else if (st_ff.ch_st[c] == CH_ON) begin
            nxt_st.tg[c] = pwm_top[c];
            nxt_st.bg[c] = pwm_bot[c] && !pwm_top[c];
         end else begin
            nxt_st.tg[c] = 1'b0;
            nxt_st.bg[c] = 1'b0;
         end
      end
      nxt_st.pull_d1 = st_ff.pull_now;
      nxt_st.pull_d2 = st_ff.pull_d1;

      // Memory blocking by die temperature, with hysteresis
      if (die_temp > TEMP_BLOCK_C) begin
         nxt_st.nvm_block = 1'b1;
      end else if (die_temp < TEMP_UNBLOCK_C) begin
         nxt_st.nvm_block = 1'b0;
      end

      // Log request waits while memory is blocked, then fires once
      nxt_st.log_store = 1'b0;
      if (fault_log_en && any_off) begin
         nxt_st.log_pend = 1'b1;
      end else if (st_ff.log_pend && !st_ff.nvm_block) begin
         nxt_st.log_pend  = 1'b0;
         nxt_st.log_store = 1'b1;
      end

      // Peak tracking runs continuously
      if (peak_meas > st_ff.peak) begin
         nxt_st.peak = peak_meas;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff      <= '0;
         st_ff.peak <= PEAK_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Open-drain enables: each pin is only ever pulled low
   assign fault_line_n_oe = st_ff.pull_now;
   assign channel_on_request_n_oe = {NUM_CH{!seq_ok}};
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         power_good_n_oe[c] = st_ff.ch_st[c] != CH_ON;
         pwm_enable[c]      = st_ff.ch_st[c] == CH_ON;
      end
   end
   assign sync_oe = sync_out_en &&
                    (st_ff.sync_cnt < CNT_W'(SYNC_LOW_CYC));
   assign share_clk_oe = !st_ff.vin_ok ||
                         (st_ff.tb_cnt < CNT_W'(TB_LOW_CYC));
   assign alert_n_oe = st_ff.cml_flt || st_ff.pwrup_flt ||
                       (st_ff.ext_flt && !alert_mask_ext);
   // Clock stretching is not used, so the clock pin is never pulled
   assign scl_oe = 1'b0;
   assign sda_oe = lk_ff.ack;

   // Outputs and status
   assign top_gate_drive    = st_ff.tg;
   assign bottom_gate_drive = st_ff.bg;
   assign nvm_log_store     = st_ff.log_store;
   assign nvm_grant         = nvm_req && !st_ff.nvm_block;
   assign peak_hdr          = st_ff.peak;
   always_comb begin
      common_status_byte                = 8'h00;
      common_status_byte[ST_VIN_OK]     = st_ff.vin_ok;
      common_status_byte[ST_NVM_BLOCK]  = st_ff.nvm_block;
      common_status_byte[ST_NEED_RST]   = st_ff.need_rst;
      common_status_byte[ST_NVM_INIT_N] = !uninit;
   end
endmodule : slfs_supervisor
`default_nettype wire

// File: verilog/_unused.sv
`default_nettype none
`default_nettype wire

// File: tb/slfs_monitor.sv
// Concurrent checks on the supervisor's ports
`timescale 1ns/1ps
`default_nettype none
module slfs_monitor (
   input wire logic                            core_clk,
   input wire logic                            resetn,
   input wire logic                            input_turn_off_threshold,
   input wire logic [slfs_pkg::NUM_CH-1:0]     pwm_enable,
   input wire logic [7:0]                      common_status_byte,
   input wire logic                            share_clk_oe,
   input wire logic                            sync_oe,
   input wire logic                            scl_oe,
   input wire logic [slfs_pkg::NUM_CH-1:0][slfs_pkg::NUM_FLT-1:0] flt_src,
   input wire logic [slfs_pkg::NUM_CH-1:0]     top_gate_drive,
   input wire logic [slfs_pkg::NUM_CH-1:0]     bottom_gate_drive,
   input wire logic                            nvm_req,
   input wire logic                            nvm_grant,
   input wire logic [7:0]                      die_temp
);
   import slfs_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Pulse shapes, measured from the rising pull
   sequence s_sync_pulse; ##12 sync_oe ##1 !sync_oe; endsequence
   sequence s_share_pulse; ##24 share_clk_oe ##1 !share_clk_oe; endsequence
   property p_hold; $rose(|pwm_enable) |-> common_status_byte[ST_VIN_OK];
   endproperty
   a_hold: assert property (p_hold)
      else $error("Channel started without input ok");
   // Off comparator seen three edges back: timebase must already be held
   property p_off; $past(input_turn_off_threshold, 3) |-> share_clk_oe;
   endproperty
   a_off: assert property (p_off)
      else $error("Timebase released while input low");
   property p_ov; flt_src[0][FLT_OV] |=>
      !top_gate_drive[0] && bottom_gate_drive[0]; endproperty
   a_ov: assert property (p_ov)
      else $error("Overvoltage did not force the gates");
   property p_sync; $rose(sync_oe) |-> s_sync_pulse; endproperty
   a_sync: assert property (p_sync)
      else $error("Sync low time wrong");
   // Lost input holds the line, so those attempts are dropped
   property p_tb; @(posedge core_clk)
      disable iff (!resetn || input_turn_off_threshold)
      $rose(share_clk_oe) && common_status_byte[ST_VIN_OK] |-> s_share_pulse;
   endproperty
   a_tb: assert property (p_tb)
      else $error("Timebase low time wrong");
   property p_grant; nvm_grant |-> nvm_req && !common_status_byte[ST_NVM_BLOCK];
   endproperty
   a_grant: assert property (p_grant)
      else $error("Memory granted while blocked");
   property p_blk; die_temp > TEMP_BLOCK_C |=> common_status_byte[ST_NVM_BLOCK];
   endproperty
   a_blk: assert property (p_blk)
      else $error("Hot die did not block memory");
   property p_unblk; die_temp < TEMP_UNBLOCK_C |=>
      !common_status_byte[ST_NVM_BLOCK]; endproperty
   a_unblk: assert property (p_unblk)
      else $error("Cool die still blocks memory");
   property p_od; scl_oe == 1'b0; endproperty
   a_od: assert property (p_od)
      else $error("Clock pin pulled by device");
endmodule : slfs_monitor
bind slfs_supervisor slfs_monitor i_mon (.*);
`default_nettype wire

// File: tb/slfs_link_host.sv
// Link-side host model issuing addresses, writes and torn transfers
`timescale 1ns/1ps
`default_nettype none
module slfs_link_host (
   input  wire logic       link_clk,
   input  wire logic       sda_oe,
   output logic            lk_addr_valid,
   output logic      [6:0] lk_addr,
   output logic            lk_wr_strobe,
   output logic      [7:0] lk_cmd,
   output logic      [7:0] lk_data,
   output logic            lk_partial
);
   // Qualifiers flip after use so a stale word is never mistaken for new
   initial begin
      {lk_addr_valid, lk_wr_strobe, lk_partial, lk_addr, lk_cmd, lk_data} = '0;
   end
   // Acknowledge stands one link cycle after the address edge
   task automatic addr(input logic [6:0] a, output logic ack);
      @(posedge link_clk);
      lk_addr_valid <= '1;
      lk_addr       <= a;
      @(posedge link_clk);
      lk_addr_valid <= '0;
      lk_addr       <= ~a;
      @(posedge link_clk);
      ack = sda_oe;
   endtask : addr
   // Writes are spaced six link cycles so none is lost crossing over
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      @(posedge link_clk);
      lk_wr_strobe <= '1;
      lk_cmd       <= c;
      lk_data      <= d;
      @(posedge link_clk);
      lk_wr_strobe <= '0;
      lk_cmd       <= ~c;
      lk_data      <= ~d;
      repeat (4) @(posedge link_clk);
   endtask : wr
   task automatic torn();
      @(posedge link_clk);
      lk_partial <= '1;
      @(posedge link_clk);
      lk_partial <= '0;
   endtask : torn
endmodule : slfs_link_host
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench of the supply lockout and fault supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
   num_errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench;
   import slfs_pkg::*;
   logic core_clk = '0, link_clk = '0, resetn = '0, ack, blk = '0;
   logic input_turn_on_threshold = '0, input_turn_off_threshold = '1;
   logic [NUM_CH-1:0] fault_line_n_i, fault_line_n_oe, ext_n = '1, run_n = '1;
   logic [NUM_CH-1:0] channel_on_request_n_i, channel_on_request_n_oe;
   logic [NUM_CH-1:0] power_good_n_oe, pwm_enable, pwm_top = '0, pwm_bot = '0;
   logic [NUM_CH-1:0] top_gate_drive, bottom_gate_drive;
   logic sync_oe, share_clk_oe, alert_n_oe, scl_oe, sda_oe;
   logic nvm_log_store, nvm_grant, nvm_req = '1, fault_log_en = '1;
   logic alert_mask_ext = '1, alert_clear = '0, sync_out_en = '1;
   logic [NUM_CH-1:0][NUM_FLT-1:0] flt_src = '0, flt_pin_mask = '1;
   logic [NUM_CH-1:0][NUM_FLT-1:0][1:0] flt_resp = {12{2'h1}};
   logic [1:0]  ext_flt_resp = 2'h0;
   logic [15:0] fault_retry_interval = 16'h0002, peak_meas = '0, peak_hdr;
   logic [6:0]  cfg_addr = 7'h31, lk_addr;
   logic [7:0]  common_status_byte, die_temp = 8'h19, lk_cmd, lk_data;
   logic [7:0]  tt [3] = '{8'h83, 8'h7d, 8'h77};
   logic        lk_addr_valid, lk_wr_strobe, lk_partial;
   logic [31:0] rnd = 32'ha7086aa8;
   int          num_errors = 0, check_count = 0, n, pk = 0;
   // Open-drain pins resolve from every puller
   assign fault_line_n_i = ~fault_line_n_oe & ext_n;
   assign channel_on_request_n_i = ~channel_on_request_n_oe & run_n;
   always #20 core_clk = ~core_clk;
   // Link clock offset so its edges never meet the core's
   initial begin
      #7;
      forever #80 link_clk = ~link_clk;
   end
   slfs_supervisor i_dut (.*);
   slfs_link_host i_host (.*);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic cyc(input int k);
      repeat (k) @(negedge core_clk);
   endtask : cyc
   task automatic clear();
      cyc(1);
      alert_clear = '1;
      cyc(1);
      alert_clear = '0;
      cyc(2);
   endtask : clear
   task automatic complete_run();
      $display("Counts: errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   // Watchdog well past the expected few tens of microseconds
   initial begin
      #500000;
      num_errors++;
      complete_run();
   end
   // Main sequence
   initial begin
      repeat (5) @(posedge link_clk);
      cyc(1);
      resetn = '1;
      repeat (4) @(posedge link_clk);
      cyc(1);
      `CHK("nvm_init", 1'b0, common_status_byte[ST_NVM_INIT_N])
      `CHK("share_hold", 1'b1, share_clk_oe)
      `CHK("pwm", 2'h0, pwm_enable)
      i_host.addr(cfg_addr, ack);
      `CHK("ack_cfg", 1'b0, ack)
      i_host.addr(ADDR_FIXED_A, ack);
      `CHK("ack_fixed", 1'b1, ack)
      i_host.addr(ADDR_GLOBAL, ack);
      i_host.wr(CMD_UNLOCK, UNLOCK_KEY1);
      i_host.wr(CMD_UNLOCK, UNLOCK_KEY2);
      cyc(4);
      `CHK("nvm_init", 1'b1, common_status_byte[ST_NVM_INIT_N])
      i_host.addr(cfg_addr, ack);
      `CHK("ack_cfg", 1'b1, ack)
      i_host.torn();
      cyc(8);
      `CHK("alert", 1'b1, alert_n_oe)
      clear();
      `CHK("alert", 1'b0, alert_n_oe)
      // Input arrives with another party holding a fault line
      ext_n[1] = '0;
      input_turn_off_threshold = '0;
      input_turn_on_threshold = '1;
      cyc(8);
      `CHK("alert", 1'b1, alert_n_oe)
      `CHK("need_rst", 1'b1, common_status_byte[ST_NEED_RST])
      ext_n[1] = '1;
      clear();
      run_n = '0;
      cyc(8);
      `CHK("pwm", 2'h0, pwm_enable)
      i_host.addr(ADDR_GLOBAL, ack);
      i_host.wr(CMD_SOFT_RESET, 8'h00);
      cyc(8);
      `CHK("pwm", 2'h3, pwm_enable)
      `CHK("pgood", 2'h0, power_good_n_oe)
      flt_src[0][FLT_OV] = '1;
      cyc(1);
      `CHK("top_gate", 1'b0, top_gate_drive[0])
      `CHK("bot_gate", 1'b1, bottom_gate_drive[0])
      `CHK("flt_pin", 2'h1, fault_line_n_oe)
      n = 0;
      repeat (6) begin
         cyc(1);
         n += (nvm_log_store === 1'b1);
      end
      `CHK("log_pulses", 1, n)
      flt_src = '0;
      cyc(4);
      `CHK("latched", 1'b0, pwm_enable[0])
      flt_resp[1][FLT_UV] = RESP_RETRY;
      flt_src[1][FLT_UV] = '1;
      cyc(1);
      flt_src = '0;
      cyc(3);
      `CHK("retry_off", 1'b0, pwm_enable[1])
      n = 0;
      while (pwm_enable[1] !== 1'b1 && n < 1000) begin
         cyc(1);
         n++;
      end
      `CHK("retry_wait", 1'b1, n >= (fault_retry_interval - 16'h1) * TB_PER_CYC
         && n <= fault_retry_interval * TB_PER_CYC + 10)
      // Memory grant against die temperature; request held high all run
      for (int i = 0; i < 3; i++) begin
         die_temp = tt[i];
         blk = (tt[i] > TEMP_BLOCK_C) | (blk & (tt[i] >= TEMP_UNBLOCK_C));
         cyc(3);
         `CHK("grant", ~blk, nvm_grant)
      end
      repeat (20) begin
         cyc(1);
         rnd = lfsr(rnd);
         {pwm_bot, pwm_top, peak_meas} = rnd[19:0];
         if (rnd[15:0] > pk) pk = rnd[15:0];
      end
      cyc(2);
      `CHK("peak_hdr", pk[15:0], peak_hdr)
      input_turn_off_threshold = '1;
      input_turn_on_threshold = '0;
      cyc(6);
      `CHK("pwm", 2'h0, pwm_enable)
      input_turn_off_threshold = '0;
      cyc(6);
      `CHK("pwm", 2'h0, pwm_enable)
      input_turn_on_threshold = '1;
      cyc(8);
      `CHK("restart", 1'b1, pwm_enable[1])
      complete_run();
   end
endmodule : testbench
`default_nettype wire
